//--- rtl/acsc_map.svh
// register offsets, field positions and reset values of the
// sample-clock and sysref control block; assumes a 32-bit apb slave
`ifndef ACSC_MAP_SVH
`define ACSC_MAP_SVH

// register indices, byte address is four times the index
`define ACSC_IDX_FINE     10'h112
`define ACSC_IDX_DETCTRL  10'h11A
`define ACSC_IDX_DETSTAT  10'h11B
`define ACSC_IDX_DCS      10'h11C
`define ACSC_IDX_SYSREF   10'h120
`define ACSC_IDX_IRQSTAT  10'h130
`define ACSC_IDX_IRQMASK  10'h131

// reset values
`define ACSC_RST_FINE     8'hC0
`define ACSC_RST_DETCTRL  8'h0E
`define ACSC_RST_DCS      8'h08
`define ACSC_RST_SYSREF   8'h00
`define ACSC_RST_IRQMASK  4'h0

// field positions
`define ACSC_DET_EN       2
`define ACSC_DET_THR_LO   3
`define ACSC_DET_THR_HI   4
`define ACSC_DCS_PWR      0
`define ACSC_DCS_EN       1
`define ACSC_SR_MODE_LO   1
`define ACSC_SR_MODE_HI   2
`define ACSC_SR_EDGE      3
`define ACSC_SR_TRANS     4
`define ACSC_SR_FLAGRST   6

// limits and interrupt bits
`define ACSC_FINE_MAX     8'hC0
`define ACSC_IRQ_CLKCHG   0
`define ACSC_IRQ_SRACC    1
`define ACSC_IRQ_SETUP    2
`define ACSC_IRQ_HOLD     3

`endif

//--- rtl/acsc_pkg.sv
// types of the sample-clock and sysref control block
// assumes acsc_map.svh for numbers
package acsc_pkg;

  // sysref mode field
  typedef enum logic [1:0] {
    ACSC_SR_OFF   = 2'b00,
    ACSC_SR_CONT  = 2'b01,
    ACSC_SR_NSHOT = 2'b10
  } acsc_srmode_t;

  // n-shot sequencer, gray along the path
  typedef enum logic [1:0] {
    ACSC_NS_IDLE  = 2'b00,
    ACSC_NS_COUNT = 2'b01,
    ACSC_NS_DONE  = 2'b11
  } acsc_nsstate_t;

  // sysref control register layout
  typedef struct packed {
    logic         rsvd7;
    logic         flagRst;
    logic         rsvd5;
    logic         transSel;
    logic         edgeSel;
    acsc_srmode_t mode;
    logic         rsvd0;
  } acsc_srctrl_t;

endpackage

//--- rtl/acsc_top.sv
// apb register block for sample-clock delay, clock detect,
// duty cycle stabilizer and sysref capture control
// assumes one 50 MHz clock; pins pass two flops before use
//
// Overview of operation
// - fine delay counts 1.725 ps steps, 0 to 192, resets to 192
// - fine delay used only in delay modes 2, 3, 4 or 6
// - enabled detector reports clock presence; threshold 01=200, 11=150 MHz
// - stabilizer has power-up and enable; power up first, else bypassed
// - flag reset bit holds setup and hold error flags cleared
// - transition select 0 accepts rising, 1 falling sysref transitions
// - mode 00 off, 01 continuous, 10 n-shot; disable before polarity change
// - edge select 0 captures on clock rising, 1 on falling edge
// - n-shot ignores 0 to 15 first transitions, then acts once
`timescale 1ns/1ps
`default_nettype none
`include "acsc_map.svh"

module acsc_top #(
  parameter int FINE_W = 8,
  parameter int NCNT_W = 4
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // interrupt
  output var  logic              irq,
  // neighbouring clock registers
  input  wire logic [2:0]        delayMode,
  input  wire logic [NCNT_W-1:0] nshotIgnore,
  // analog front end, asynchronous
  input  wire logic              clkDetRaw,
  input  wire logic              sysrefIn,
  input  wire logic              setupErrIn,
  input  wire logic              holdErrIn,
  // sample clock path controls
  output var  logic [FINE_W-1:0] fineDelayOut,
  output var  logic              fineDelayOn,
  output var  logic [1:0]        detThreshold,
  output var  logic              detEnable,
  output var  logic              dcsPowerOn,
  output var  logic              dcsActive,
  output var  logic              capFallEdge,
  output var  logic              sysrefPulse
);

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic idxHit(input logic [11:0] a,
                                  input logic [9:0]  idx);
    idxHit = (a[11:2] == idx);
  endfunction

  wire logic       acc     = psel & penable & pready;
  wire logic       wrAcc   = acc & pwrite;
  wire logic       rdAcc   = acc & ~pwrite;
  wire logic       hitFine = idxHit(paddr, `ACSC_IDX_FINE);
  wire logic       hitDetC = idxHit(paddr, `ACSC_IDX_DETCTRL);
  wire logic       hitDetS = idxHit(paddr, `ACSC_IDX_DETSTAT);
  wire logic       hitDcs  = idxHit(paddr, `ACSC_IDX_DCS);
  wire logic       hitSr   = idxHit(paddr, `ACSC_IDX_SYSREF);
  wire logic       hitIrqS = idxHit(paddr, `ACSC_IDX_IRQSTAT);
  wire logic       hitIrqM = idxHit(paddr, `ACSC_IDX_IRQMASK);
  wire logic       anyHit  = hitFine | hitDetC | hitDetS | hitDcs
                           | hitSr | hitIrqS | hitIrqM;

  // ****************************************
  // registers
  // ****************************************
  logic [7:0]           fine_r;
  logic [7:0]           detCtrl_r;
  logic                 detStatus_r;
  logic [7:0]           dcsCtrl_r;
  acsc_pkg::acsc_srctrl_t srCtrl_r;
  logic [3:0]           irqStat_r;
  logic [3:0]           irqMask_r;
  logic [3:0]           irqStat_nxt;

  wire logic [7:0] wByte = pwdata[7:0];

  // sysref write fields; reserved bits kept zero
  wire acsc_pkg::acsc_srctrl_t srWr = '{
    rsvd7:    1'b0,
    flagRst:  wByte[`ACSC_SR_FLAGRST],
    rsvd5:    1'b0,
    transSel: wByte[`ACSC_SR_TRANS],
    edgeSel:  wByte[`ACSC_SR_EDGE],
    mode:     acsc_pkg::acsc_srmode_t'(wByte[`ACSC_SR_MODE_HI:`ACSC_SR_MODE_LO]),
    rsvd0:    1'b0
  };

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fine_r    <= `ACSC_RST_FINE;
      detCtrl_r <= `ACSC_RST_DETCTRL;
      dcsCtrl_r <= `ACSC_RST_DCS;
      srCtrl_r  <= `ACSC_RST_SYSREF;
      irqMask_r <= `ACSC_RST_IRQMASK;
    end else if (wrAcc) begin
      if (hitFine) fine_r    <= wByte;
      if (hitDetC) detCtrl_r <= wByte;
      if (hitDcs)  dcsCtrl_r <= {wByte[7:3], 1'b0, wByte[1:0]};
      if (hitSr)   srCtrl_r  <= srWr;
      if (hitIrqM) irqMask_r <= wByte[3:0];
    end
  end

  // ****************************************
  // apb answer, one wait state
  // ****************************************
  wire logic [7:0] rdMux =
      hitFine ? fine_r :
      hitDetC ? detCtrl_r :
      hitDetS ? {7'h00, detStatus_r} :
      hitDcs  ? dcsCtrl_r :
      hitSr   ? srCtrl_r :
      hitIrqS ? {4'h0, irqStat_r} :
      hitIrqM ? {4'h0, irqMask_r} : 8'h00;

  wire logic takeReq = psel & penable & ~pready;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= takeReq;
      prdata  <= takeReq ? {24'h00_0000, rdMux} : prdata;
      pslverr <= takeReq & ~anyHit;
    end
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic clkDetMeta_r;
  logic clkDetSync_r;
  logic srMeta_r;
  logic srSync_r;
  logic srPrev_r;
  logic setupMeta_r;
  logic setupSync_r;
  logic holdMeta_r;
  logic holdSync_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clkDetMeta_r <= 1'b0;
      clkDetSync_r <= 1'b0;
      srMeta_r     <= 1'b0;
      srSync_r     <= 1'b0;
      srPrev_r     <= 1'b0;
      setupMeta_r  <= 1'b0;
      setupSync_r  <= 1'b0;
      holdMeta_r   <= 1'b0;
      holdSync_r   <= 1'b0;
    end else begin
      clkDetMeta_r <= clkDetRaw;
      clkDetSync_r <= clkDetMeta_r;
      srMeta_r     <= sysrefIn;
      srSync_r     <= srMeta_r;
      srPrev_r     <= srSync_r;
      setupMeta_r  <= setupErrIn;
      setupSync_r  <= setupMeta_r;
      holdMeta_r   <= holdErrIn;
      holdSync_r   <= holdMeta_r;
    end
  end

  // ****************************************
  // clock path controls
  // ****************************************
  wire logic fineModeOk = (delayMode == 3'h2) | (delayMode == 3'h3)
                        | (delayMode == 3'h4) | (delayMode == 3'h6);
  wire logic [7:0] fineClamp = (fine_r > `ACSC_FINE_MAX) ?
                               `ACSC_FINE_MAX : fine_r;
  wire logic detEnBit  = detCtrl_r[`ACSC_DET_EN];
  wire logic detNxt    = detEnBit & clkDetSync_r;
  wire logic dcsPwrBit = dcsCtrl_r[`ACSC_DCS_PWR];
  wire logic dcsEnBit  = dcsCtrl_r[`ACSC_DCS_EN];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fineDelayOut <= '0;
      fineDelayOn  <= 1'b0;
      detStatus_r  <= 1'b0;
      detThreshold <= 2'h1;
      detEnable    <= 1'b0;
      dcsPowerOn   <= 1'b0;
      dcsActive    <= 1'b0;
      capFallEdge  <= 1'b0;
    end else begin
      fineDelayOut <= fineModeOk ? fineClamp[FINE_W-1:0] : '0;
      fineDelayOn  <= fineModeOk;
      detStatus_r  <= detNxt;
      detThreshold <= detCtrl_r[`ACSC_DET_THR_HI:`ACSC_DET_THR_LO];
      detEnable    <= detEnBit;
      dcsPowerOn   <= dcsPwrBit;
      dcsActive    <= dcsPwrBit & dcsEnBit;
      capFallEdge  <= srCtrl_r.edgeSel;
    end
  end

  // ****************************************
  // sysref acceptance
  // ****************************************
  acsc_pkg::acsc_nsstate_t nsState_r;
  acsc_pkg::acsc_nsstate_t nsState_nxt;
  logic [NCNT_W-1:0]       ignoreCnt_r;
  logic [NCNT_W-1:0]       ignoreCnt_nxt;
  logic                    nsFire;

  wire logic srRise  = srSync_r & ~srPrev_r;
  wire logic srFall  = ~srSync_r & srPrev_r;
  wire logic srValid = srCtrl_r.transSel ? srFall : srRise;
  wire logic srWrite = wrAcc & hitSr;
  wire logic contOn  = (srCtrl_r.mode == acsc_pkg::ACSC_SR_CONT);
  wire logic nshotOn = (srCtrl_r.mode == acsc_pkg::ACSC_SR_NSHOT);

  always_comb begin
    nsState_nxt   = nsState_r;
    ignoreCnt_nxt = ignoreCnt_r;
    nsFire        = 1'b0;
    case (nsState_r)
      acsc_pkg::ACSC_NS_IDLE: begin
        if (nshotOn) begin
          nsState_nxt   = acsc_pkg::ACSC_NS_COUNT;
          ignoreCnt_nxt = nshotIgnore;
        end
      end
      acsc_pkg::ACSC_NS_COUNT: begin
        if (!nshotOn) begin
          nsState_nxt = acsc_pkg::ACSC_NS_IDLE;
        end else if (srValid && ignoreCnt_r == '0) begin
          nsFire      = 1'b1;
          nsState_nxt = acsc_pkg::ACSC_NS_DONE;
        end else if (srValid) begin
          ignoreCnt_nxt = ignoreCnt_r - 1'b1;
        end
      end
      acsc_pkg::ACSC_NS_DONE: begin
        if (!nshotOn) begin
          nsState_nxt = acsc_pkg::ACSC_NS_IDLE;
        end
      end
      default: begin
        nsState_nxt = acsc_pkg::ACSC_NS_IDLE;
      end
    endcase
    if (srWrite) begin
      nsState_nxt = acsc_pkg::ACSC_NS_IDLE;
    end
  end

  wire logic srAccept = (contOn & srValid) | nsFire;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      nsState_r   <= acsc_pkg::ACSC_NS_IDLE;
      ignoreCnt_r <= '0;
      sysrefPulse <= 1'b0;
    end else begin
      nsState_r   <= nsState_nxt;
      ignoreCnt_r <= ignoreCnt_nxt;
      sysrefPulse <= srAccept;
    end
  end

  // ****************************************
  // interrupt status, read clears, set wins
  // ****************************************
  wire logic [3:0] irqSet = {holdSync_r, setupSync_r, srAccept,
                             detNxt ^ detStatus_r};
  // clear only the bits returned, so a late set is not lost
  wire logic [3:0] irqClr = (rdAcc & hitIrqS) ? prdata[3:0] : 4'h0;
  // mask as it stands after this edge, so irq tracks a mask write
  wire logic [3:0] irqMask_nxt = (wrAcc & hitIrqM) ? wByte[3:0] : irqMask_r;
  wire logic [3:0] flagHold = srCtrl_r.flagRst ? 4'hC : 4'h0;

  assign irqStat_nxt = ((irqStat_r & ~irqClr) | irqSet) & ~flagHold;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irqStat_r <= 4'h0;
      irq       <= 1'b0;
    end else begin
      irqStat_r <= irqStat_nxt;
      irq       <= |(irqStat_nxt & irqMask_nxt);
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  fine_range_a: assert property (
    fineDelayOut <= `ACSC_FINE_MAX)
    else $error("fine delay beyond 192 steps");

  fine_mode_a: assert property (
    !fineModeOk |=> (fineDelayOut == '0) && !fineDelayOn)
    else $error("fine delay applied in wrong delay mode");

  det_follow_a: assert property (
    detEnBit && clkDetSync_r |=> detStatus_r)
    else $error("detected clock not reported");

  det_off_a: assert property (
    !detEnBit |=> !detStatus_r)
    else $error("detect status set while disabled");

  dcs_order_a: assert property (
    dcsActive |-> dcsPowerOn)
    else $error("stabilizer active while powered down");

  flag_hold_a: assert property (
    srCtrl_r.flagRst |=> irqStat_r[3:2] == 2'b00)
    else $error("error flags set during flag reset");

  edge_pol_a: assert property (
    contOn && !srCtrl_r.transSel && srRise && !srWrite |=> sysrefPulse)
    else $error("rising sysref not accepted");

  edge_none_a: assert property (
    srSync_r == srPrev_r |=> !sysrefPulse)
    else $error("sysref accepted without transition");

  cap_edge_a: assert property (
    $rose(srCtrl_r.edgeSel) |=> capFallEdge)
    else $error("capture edge not following select");

  nshot_skip_a: assert property (
    nsState_r == acsc_pkg::ACSC_NS_COUNT && ignoreCnt_r != '0
    |=> !sysrefPulse)
    else $error("n-shot fired before ignore count spent");

  nshot_once_a: assert property (
    nsState_r == acsc_pkg::ACSC_NS_DONE && !contOn |=> !sysrefPulse)
    else $error("n-shot fired twice");

  irq_level_a: assert property (
    irq == |(irqStat_r & irqMask_r))
    else $error("interrupt output wrong");

endmodule
`default_nettype wire

//--- verif/acsc_partner.sv
// clock source and sysref generator model at the device pins
// assumes the bench requests levels; pins move on the falling edge
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// far side pin model
// ****************************************
module acsc_partner (
  // clock
  input  wire logic ref_clk,
  // bench requests
  input  wire logic clkOn,
  input  wire logic srLevel,
  input  wire logic setupReq,
  input  wire logic holdReq,
  // device pins
  output var  logic clkDetRaw,
  output var  logic sysrefIn,
  output var  logic setupErrIn,
  output var  logic holdErrIn
);
  initial begin
    clkDetRaw  = 1'b0;
    sysrefIn   = 1'b0;
    setupErrIn = 1'b0;
    holdErrIn  = 1'b0;
  end
  // levels change away from the sampling edge
  always @(negedge ref_clk) begin
    clkDetRaw  <= clkOn;
    sysrefIn   <= srLevel;
    setupErrIn <= setupReq;
    holdErrIn  <= holdReq;
  end
endmodule
`default_nettype wire

//--- verif/acsc_tb_top.sv
// self-checking bench of the sample-clock and sysref control block
// assumes acsc_top and the pin model acsc_partner
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// bench top
// ****************************************
module acsc_tb_top;
  logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic        perr, clkOn, srLevel, setupReq, holdReq;
  logic [2:0]  delayMode;
  logic [3:0]  nshotIgnore;
  logic        clkDetRaw, sysrefIn, setupErrIn, holdErrIn;
  logic [7:0]  fineDelayOut, fv;
  logic [1:0]  detThreshold;
  logic        fineDelayOn, detEnable, dcsPowerOn, dcsActive, capFallEdge, sysrefPulse;
  int          errors, check_count, pulses, p0;
  int          igTab[3] = '{0, 2, 15};

  acsc_top dut_u (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .delayMode(delayMode), .nshotIgnore(nshotIgnore),
    .clkDetRaw(clkDetRaw), .sysrefIn(sysrefIn), .setupErrIn(setupErrIn),
    .holdErrIn(holdErrIn), .fineDelayOut(fineDelayOut), .fineDelayOn(fineDelayOn),
    .detThreshold(detThreshold), .detEnable(detEnable), .dcsPowerOn(dcsPowerOn),
    .dcsActive(dcsActive), .capFallEdge(capFallEdge), .sysrefPulse(sysrefPulse));

  acsc_partner far_u (.ref_clk(ref_clk), .clkOn(clkOn), .srLevel(srLevel),
    .setupReq(setupReq), .holdReq(holdReq), .clkDetRaw(clkDetRaw),
    .sysrefIn(sysrefIn), .setupErrIn(setupErrIn), .holdErrIn(holdErrIn));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (sysrefPulse === 1'b1) begin
      pulses++;
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic logic [31:0] expFine(input int v, input int m);
    if (m == 2 || m == 3 || m == 4 || m == 6) begin
      return (v > 192) ? 192 : v;
    end
    return 0;
  endfunction

  task automatic stop_test();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      stop_test();
    end
    rd      = prdata;
    perr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic srToggle(input int n);
    repeat (n) begin
      srLevel <= ~srLevel;
      cyc(8);
    end
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {clkOn, srLevel, setupReq, holdReq, delayMode, nshotIgnore} = '0;
    seed = 32'hBBC0;
    rstn = 1'b0;
    cyc(4);
    rstn <= 1'b1;
    cyc(1);
    // reset values and unmapped index
    rdchk(12'h448, 32'h000000C0);
    rdchk(12'h468, 32'h0000000E);
    rdchk(12'h46C, 32'h00000000);
    rdchk(12'h480, 32'h00000000);
    apb(1'b0, 12'h7FC, 32'h0);
    chk({31'h0, perr}, 32'h00000001);
    // fine delay against every delay mode
    for (int k = 0; k < 10; k++) begin
      seed = xs(seed);
      fv = (k == 0) ? 8'hC0 : (k == 1) ? 8'hC1 : seed[7:0];
      apb(1'b1, 12'h448, {24'h0, fv});
      for (int m = 0; m < 8; m++) begin
        delayMode <= m[2:0];
        cyc(3);
        chk({24'h0, fineDelayOut}, expFine(fv, m));
        chk({31'h0, fineDelayOn}, {31'h0, expFine(1, m) == 1});
      end
    end
    // clock detect
    clkOn <= 1'b1;
    cyc(8);
    rdchk(12'h46C, 32'h00000001);
    apb(1'b1, 12'h468, 32'h18);
    cyc(2);
    chk({30'h0, detThreshold}, 32'h00000003);
    chk({31'h0, detEnable}, 32'h00000000);
    rdchk(12'h46C, 32'h00000000);
    apb(1'b1, 12'h468, 32'h0C);
    cyc(6);
    chk({29'h0, detEnable, detThreshold}, 32'h00000005);
    rdchk(12'h46C, 32'h00000001);
    clkOn <= 1'b0;
    cyc(8);
    rdchk(12'h46C, 32'h00000000);
    // stabilizer powered up before enable
    apb(1'b1, 12'h470, 32'h01);
    cyc(2);
    chk({30'h0, dcsPowerOn, dcsActive}, 32'h00000002);
    apb(1'b1, 12'h470, 32'h03);
    cyc(2);
    chk({31'h0, dcsActive}, 32'h00000001);
    // continuous mode, rising, falling capture edge
    apb(1'b1, 12'h480, 32'h0A);
    cyc(2);
    chk({31'h0, capFallEdge}, 32'h00000001);
    p0 = pulses;
    srToggle(4);
    chk(pulses - p0, 32'h00000002);
    apb(1'b1, 12'h480, 32'h00);
    p0 = pulses;
    srToggle(2);
    chk(pulses - p0, 32'h00000000);
    apb(1'b1, 12'h480, 32'h10);
    apb(1'b1, 12'h480, 32'h12);
    p0 = pulses;
    srToggle(4);
    chk(pulses - p0, 32'h00000002);
    // n-shot with ignore counts
    apb(1'b1, 12'h480, 32'h10);
    foreach (igTab[i]) begin
      apb(1'b1, 12'h480, 32'h00);
      nshotIgnore <= igTab[i][3:0];
      cyc(2);
      apb(1'b1, 12'h480, 32'h04);
      p0 = pulses;
      srToggle(2 * (igTab[i] + 3));
      chk(pulses - p0, 32'h00000001);
    end
    // interrupt on accepted sysref
    apb(1'b1, 12'h480, 32'h02);
    apb(1'b0, 12'h4C0, 32'h0);
    apb(1'b1, 12'h4C4, 32'h02);
    srToggle(2);
    chk({31'h0, irq}, 32'h00000001);
    rdchk(12'h4C0, 32'h00000002);
    chk({31'h0, irq}, 32'h00000000);
    // flag reset holds error flags clear
    apb(1'b1, 12'h4C4, 32'h0C);
    apb(1'b1, 12'h480, 32'h40);
    setupReq <= 1'b1;
    holdReq  <= 1'b1;
    cyc(8);
    chk({31'h0, irq}, 32'h00000000);
    rdchk(12'h4C0, 32'h00000000);
    apb(1'b1, 12'h480, 32'h00);
    cyc(8);
    chk({31'h0, irq}, 32'h00000001);
    rdchk(12'h4C0, 32'h0000000C);
    stop_test();
  end
endmodule
`default_nettype wire
